/* verilog/tps_pkg.sv */
`default_nettype none
package tps_pkg;

  // ------------------------------------------------------------
  // Pattern memory geometry
  // ------------------------------------------------------------
  localparam int unsigned PM_DEPTH   = 4096;
  localparam int unsigned PM_AW      = 12;
  localparam int unsigned SMP_W      = 12;
  localparam int unsigned PM_CHANS   = 8;
  localparam int unsigned PM_BINS    = 512;

  // ------------------------------------------------------------
  // Fixed data values
  // ------------------------------------------------------------
  localparam logic [11:0] PULSE_AMP  = 12'h800;
  localparam logic [11:0] FRAME_WORD = 12'hfc0;
  localparam logic [11:0] ZERO_WORD  = 12'h000;
  localparam logic [15:0] DROP_MASK  = 16'h0008;

  // ------------------------------------------------------------
  // Reset values of the test controls
  // ------------------------------------------------------------
  localparam logic RST_TEST_EN  = 1'b0;
  localparam logic RST_TEST_SEL = 1'b0;
  localparam logic RST_ZBT      = 1'b0;
  localparam logic RST_KEEP_FR  = 1'b0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FILL_RAMP_UP,
    FILL_RAMP_DN,
    FILL_PULSE
  } tps_fill_e;

  typedef struct packed {
    logic test_enable;
    logic test_mode;
    logic test_zbt;
    logic keep_frame;
  } tps_cfg_s;

  typedef struct packed {
    logic [3:0]       chip;
    logic [SMP_W-1:0] data;
  } tps_smp_s;

endpackage : tps_pkg
`default_nettype wire

/* verilog/tps_top.sv */
`default_nettype none
module tps_top
  import tps_pkg::*;
#(
  parameter int unsigned      EB_AW     = 20,
  parameter logic [15:0]      DROP_CHIP = DROP_MASK
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Test control bits
  input  wire logic             cfg_wr,
  input  wire tps_cfg_s         cfg_wdata,
  output tps_cfg_s              cfg_rdata,
  // Pattern memory host access
  input  wire logic             pm_wr,
  input  wire logic             pm_rd,
  input  wire logic [PM_AW-1:0] pm_addr,
  input  wire logic [SMP_W-1:0] pm_wdata,
  output logic [SMP_W-1:0]      pm_rdata,
  output logic                  pm_rvalid,
  // Predefined fill command
  input  wire logic             fill_start,
  input  wire tps_fill_e        fill_kind,
  input  wire logic [PM_AW-1:0] fill_arg,
  output logic                  fill_busy,
  // Sample stream from array readout
  input  wire logic             smp_valid,
  output logic                  smp_ready,
  input  wire tps_smp_s         smp_in,
  input  wire logic [SMP_W-1:0] smp_rd_addr,
  // Stream to zero suppression
  output logic                  zs_valid,
  input  wire logic             zs_ready,
  output tps_smp_s              zs_out,
  // Event buffer write path
  input  wire logic             eb_in_wr,
  input  wire logic [EB_AW-1:0] eb_in_addr,
  input  wire logic [SMP_W-1:0] eb_in_data,
  output logic                  eb_wr,
  output logic [EB_AW-1:0]      eb_addr,
  output logic [SMP_W-1:0]      eb_data
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------

  // Fill sequencer states:
  // idle waits for a fill command,
  // run owns the memory write port for one full sweep.
  // A fill always sweeps every address, whatever the period,
  // so no stale word survives from an earlier pattern.
  typedef enum logic {
    FS_IDLE,
    FS_RUN
  } tps_fsm_e;

  // Pattern storage, one word per address
  logic [SMP_W-1:0] pm_mem [PM_DEPTH];
  // Host-visible control bits
  tps_cfg_s         cfg_q;
  tps_fsm_e         fs_q;
  tps_fill_e        fkind_q;
  logic [PM_AW-1:0] faddr_q;
  logic [PM_AW-1:0] fphase_q;
  logic [PM_AW-1:0] fper_q;
  logic [SMP_W-1:0] fword;
  // Replay position for the test stream
  logic [PM_AW-1:0] play_q;
  // Shared write port of the pattern storage
  logic             mem_we;
  logic [PM_AW-1:0] mem_wa;
  logic [SMP_W-1:0] mem_wd;
  // Output buffer: two slots, pointers and occupancy
  logic             push;
  tps_smp_s         src_word;
  tps_smp_s         buf_q [2];
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic [1:0]       cnt_q;
  logic             pop;

  // Chip drop decode, used by the stream source selection
  function automatic logic chip_dropped(input logic [3:0] chip);
    chip_dropped = DROP_CHIP[chip];
  endfunction : chip_dropped

  // ------------------------------------------------------------
  // Test control bits
  // ------------------------------------------------------------

  // Host-written control bits, cleared by reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q.test_enable <= RST_TEST_EN;
      cfg_q.test_mode   <= RST_TEST_SEL;
      cfg_q.test_zbt    <= RST_ZBT;
      cfg_q.keep_frame  <= RST_KEEP_FR;
    end else if (cfg_wr) begin
      cfg_q <= cfg_wdata;
    end
  end

  // Readback of current control state
  assign cfg_rdata = cfg_q;

  // ------------------------------------------------------------
  // Predefined fill sequencer
  // ------------------------------------------------------------

  // Word generated for the current fill position
  always_comb begin
    case (fkind_q)
      FILL_RAMP_UP: fword = fphase_q;
      FILL_RAMP_DN: fword = fper_q - fphase_q;
      FILL_PULSE:   fword = (fphase_q == '0) ? PULSE_AMP : ZERO_WORD;
      default:      fword = ZERO_WORD;
    endcase
  end

  // Fill state machine walks the whole memory once.
  // A command while a fill runs is ignored; the
  // host must wait for the busy flag to drop.
  // The sweep takes one cycle per word, so a
  // fill of the full depth lasts 4096 cycles.
  always_ff @(posedge mclk) begin
    if (rst) begin
      fs_q <= FS_IDLE;
    end else begin
      case (fs_q)
        FS_IDLE: begin
          if (fill_start) begin
            fs_q <= FS_RUN;
          end
        end
        FS_RUN: begin
          if (faddr_q == PM_AW'(PM_DEPTH - 1)) begin
            fs_q <= FS_IDLE;
          end
        end
        default: fs_q <= FS_IDLE;
      endcase
    end
  end

  // Fill address, period phase and latched arguments
  always_ff @(posedge mclk) begin
    if (rst) begin
      fkind_q  <= FILL_RAMP_UP;
      faddr_q  <= '0;
      fphase_q <= '0;
      fper_q   <= '0;
    end else if (fs_q == FS_IDLE) begin
      if (fill_start) begin
        fkind_q  <= fill_kind;
        fper_q   <= fill_arg - PM_AW'(1);  // Argument of zero gives full depth
        faddr_q  <= '0;
        fphase_q <= '0;
      end
    end else begin
      faddr_q <= faddr_q + PM_AW'(1);
      if (fphase_q == fper_q) begin
        fphase_q <= '0;
      end else begin
        fphase_q <= fphase_q + PM_AW'(1);
      end
    end
  end

  assign fill_busy = (fs_q == FS_RUN);

  // ------------------------------------------------------------
  // Pattern memory
  // ------------------------------------------------------------

  // Single write port; host writes ignored during a fill.
  // The fill has priority so that its sweep is never
  // broken by a stray host write; such writes are lost
  // without any notice, which the host must allow for.
  always_comb begin
    if (fs_q == FS_RUN) begin
      mem_we = 1'b1;
      mem_wa = faddr_q;
      mem_wd = fword;
    end else begin
      mem_we = pm_wr;
      mem_wa = pm_addr;
      mem_wd = pm_wdata;
    end
  end

  // Storage of 4096 words of 12 bits
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      pm_mem[mem_wa] <= mem_wd;
    end
  end

  // Host readback, one cycle after the request.
  // A read of an address written in the same cycle
  // returns the old word; the new one is seen a
  // cycle later.  Read data holds until the next read.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pm_rdata  <= '0;
      pm_rvalid <= 1'b0;
    end else begin
      pm_rvalid <= pm_rd;
      if (pm_rd) begin
        pm_rdata <= pm_mem[pm_addr];
      end
    end
  end

  // Replay pointer, wraps at the memory depth.
  // It restarts from address zero whenever the test
  // source or the pattern select is turned off, so
  // each replay run starts at the head of the pattern.
  // Wrap is natural overflow of the address width.
  always_ff @(posedge mclk) begin
    if (rst || !cfg_q.test_enable || !cfg_q.test_mode) begin
      play_q <= '0;
    end else if (push) begin
      play_q <= play_q + PM_AW'(1);
    end
  end

  // ------------------------------------------------------------
  // Stream source selection
  // ------------------------------------------------------------

  // Pick array data, address counter or pattern word.
  // Framing substitution is applied last, so it also
  // overrides the test sources for the dropped chips.
  // Chip number always passes through unchanged.
  always_comb begin
    src_word.chip = smp_in.chip;
    if (!cfg_q.test_enable) begin
      src_word.data = smp_in.data;
    end else if (!cfg_q.test_mode) begin
      src_word.data = smp_rd_addr;
    end else begin
      src_word.data = pm_mem[play_q];
    end
    if (cfg_q.keep_frame && chip_dropped(smp_in.chip)) begin
      src_word.data = FRAME_WORD;
    end
  end

  // ------------------------------------------------------------
  // Two-entry output buffer
  // ------------------------------------------------------------

  // Ready only while a slot is free, so a stalled
  // receiver never causes a word to be lost.
  // Valid whenever at least one slot is occupied.
  assign smp_ready = (cnt_q != 2'd2);
  assign push      = smp_valid && smp_ready;
  assign zs_valid  = (cnt_q != 2'd0);
  assign pop       = zs_valid && zs_ready;

  // Framing words are pushed like data, so later stages still see them
  always_ff @(posedge mclk) begin
    if (push) begin
      buf_q[wr_ptr_q] <= src_word;
    end
  end

  // Buffer pointers and fill count
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 2'd1;
        2'b01:   cnt_q <= cnt_q - 2'd1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  assign zs_out = buf_q[rd_ptr_q];

  // ------------------------------------------------------------
  // Event buffer write data
  // ------------------------------------------------------------

  // Registered write with data source chosen by address-as-data bit.
  // Address and strobe are delayed alongside the data,
  // so the three stay aligned one cycle after the input.
  // Only the low address bits fit the sample width.
  always_ff @(posedge mclk) begin
    if (rst) begin
      eb_wr   <= 1'b0;
      eb_addr <= '0;
      eb_data <= '0;
    end else begin
      eb_wr   <= eb_in_wr;
      eb_addr <= eb_in_addr;
      if (cfg_q.test_zbt) begin
        eb_data <= eb_in_addr[SMP_W-1:0];
      end else begin
        eb_data <= eb_in_data;
      end
    end
  end

endmodule : tps_top
`default_nettype wire

/* test/tps_checker.sv */
`default_nettype none
module tps_checker
  import tps_pkg::*;
#(parameter int unsigned EB_AW = 20) (
  // Clock and reset
  input wire logic             mclk,
  input wire logic             rst,
  // Controls and host access
  input wire logic             cfg_wr,
  input wire tps_cfg_s         cfg_wdata,
  input wire tps_cfg_s         cfg_rdata,
  input wire logic             pm_rd,
  input wire logic             pm_rvalid,
  input wire logic             fill_start,
  input wire logic             fill_busy,
  // Streams
  input wire logic             smp_valid,
  input wire logic             smp_ready,
  input wire tps_smp_s         smp_in,
  input wire logic             zs_valid,
  input wire logic             zs_ready,
  input wire tps_smp_s         zs_out,
  input wire logic [EB_AW-1:0] eb_in_addr,
  input wire logic [11:0]      eb_in_data,
  input wire logic [11:0]      eb_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Helpers: low address bits, take into empty buffer
  wire logic [11:0] addr_lo = eb_in_addr[11:0];
  wire logic        take    = smp_valid && smp_ready && !zs_valid;
  // ------
  // Checks
  // ------
  a_cfg_echo: assert property (cfg_wr |=> cfg_rdata == $past(cfg_wdata))
    else $error("config readback differs");
  a_read_answer: assert property (1'b1 |=> pm_rvalid == $past(pm_rd))
    else $error("read answer not one cycle later");
  a_fill_runs: assert property (fill_start && !fill_busy |=> fill_busy [*8])
    else $error("fill did not start");
  a_eb_source: assert property (1'b1 |=> eb_data == ($past(cfg_rdata.test_zbt) ?
    $past(addr_lo) : $past(eb_in_data))) else $error("buffer data source wrong");
  a_zs_hold: assert property (zs_valid && !zs_ready |=> zs_valid && $stable(zs_out))
    else $error("stalled word changed");
  a_src_direct: assert property (take && cfg_rdata == 4'h0 |=> zs_out == $past(smp_in))
    else $error("direct sample not passed");
  a_frame_sub: assert property (take && cfg_rdata.keep_frame && smp_in.chip == 4'h3
    |=> zs_out.data == 12'hfc0) else $error("framing word missing");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> cfg_rdata == 4'h0
    && !fill_busy && !zs_valid) else $error("reset state wrong");
endmodule : tps_checker
bind tps_top tps_checker #(.EB_AW(EB_AW)) chk_i (.*);
`default_nettype wire

/* test/tps_zs_sink.sv */
`default_nettype none
module tps_zs_sink (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Stall request
  input  wire logic stall,
  // Stream handshake
  output var  logic zs_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Random back-pressure, solid while stalled
  always @(posedge mclk) begin
    zs_ready <= !rst && !stall && ($urandom % 4 != 0);
  end
endmodule : tps_zs_sink
`default_nettype wire

/* test/tps_top_bench.sv */
`default_nettype none
module tps_top_bench
  import tps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, pm_wr = 1'b0, pm_rd = 1'b0;
  logic fill_start = 1'b0, smp_valid = 1'b0, eb_in_wr = 1'b0, stall = 1'b0;
  logic [11:0] pm_addr = '0, pm_wdata = '0, fill_arg = '0, smp_rd_addr = '0;
  logic [11:0] eb_in_data = '0, pm_rdata, eb_data;
  logic [19:0] eb_in_addr = '0, eb_addr;
  logic pm_rvalid, fill_busy, smp_ready, zs_valid, zs_ready, eb_wr;
  tps_cfg_s cfg_wdata = '0, cfg_rdata;
  tps_fill_e fill_kind = FILL_RAMP_UP;
  tps_smp_s smp_in = '0, zs_out;
  int fails = 0, tests_run = 0, play = 0;
  logic [15:0] exp_q[$];
  tps_top dut (.*);
  tps_zs_sink sink (.*);
  always #2.5 mclk = ~mclk;
  // --------------
  // Bench helpers
  // --------------
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask : chk
  task automatic stop_test();
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic hang();
    fails++;
    stop_test();
  endtask : hang
  function automatic logic [11:0] fval(tps_fill_e f, logic [11:0] arg, int a);
    int p = (arg == 0) ? 4096 : arg;
    int ph = a % p;
    case (f)
      FILL_RAMP_UP: return 12'(ph);
      FILL_RAMP_DN: return 12'(p - 1 - ph);
      default:      return (ph == 0) ? 12'h800 : 12'h000;
    endcase
  endfunction : fval
  task automatic cfg(tps_cfg_s v);
    @(posedge mclk);
    cfg_wr    <= 1'b1;
    cfg_wdata <= v;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    #1 chk("cfg_rdata", 16'(v), 16'(cfg_rdata));
    if (!(v.test_enable && v.test_mode)) play = 0;
  endtask : cfg
  task automatic pm_write(logic [11:0] a, logic [11:0] d);
    @(posedge mclk);
    pm_wr    <= 1'b1;
    pm_addr  <= a;
    pm_wdata <= d;
    @(posedge mclk);
    pm_wr <= 1'b0;
  endtask : pm_write
  task automatic pm_read(logic [11:0] a, logic [11:0] e);
    @(posedge mclk);
    pm_rd   <= 1'b1;
    pm_addr <= a;
    @(posedge mclk);
    pm_rd <= 1'b0;
    #1 chk("pm_rdata", {4'h1, e}, {3'h0, pm_rvalid, pm_rdata});
  endtask : pm_read
  task automatic fill(tps_fill_e f, logic [11:0] arg);
    logic [11:0] a;
    @(posedge mclk);
    fill_start <= 1'b1;
    fill_kind  <= f;
    fill_arg   <= arg;
    @(posedge mclk);
    fill_start <= 1'b0;
    pm_write(12'h000, 12'h5a5); // Dropped while busy
    for (int k = 0; fill_busy !== 1'b0; k++) begin
      if (k > 5000) hang();
      @(posedge mclk);
    end
    for (int i = 0; i < 8; i++) begin
      a = (i < 2) ? 12'(i) : (i == 2) ? 12'hfff : 12'($urandom);
      pm_read(a, fval(f, arg, a));
    end
  endtask : fill
  task automatic send(tps_cfg_s c, int n);
    tps_smp_s s;
    logic [11:0] ra;
    int k;
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      s  = tps_smp_s'($urandom);
      ra = 12'($urandom);
      if (i % 4 == 0) s.chip = 4'h3;
      smp_valid   <= 1'b1;
      smp_in      <= s;
      smp_rd_addr <= ra;
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (!smp_ready && k < 200);
      if (k >= 200) hang();
      if (c.keep_frame && s.chip == 4'h3) begin
        s.data = 12'hfc0;
      end else if (c.test_enable) begin
        s.data = c.test_mode ? fval(FILL_RAMP_UP, 12'h7, play) : ra;
      end
      play = (c.test_enable && c.test_mode) ? (play + 1) % 4096 : 0;
      exp_q.push_back(s);
    end
    smp_valid <= 1'b0;
  endtask : send
  task automatic drain();
    for (int k = 0; exp_q.size() != 0; k++) begin
      if (k > 200) hang();
      @(posedge mclk);
    end
  endtask : drain
  // Far-side scoreboard
  always @(posedge mclk) begin
    if (zs_valid === 1'b1 && zs_ready === 1'b1) begin
      chk("zs_out", exp_q.pop_front(), zs_out);
    end
  end
  // -------------
  // Main sequence
  // -------------
  initial begin
    logic [11:0] a, d;
    tps_cfg_s modes[4] = '{4'h0, 4'h8, 4'h1, 4'hc};
    void'($urandom(32'hfb9a3b48));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1 chk("reset", 16'h1, 16'({cfg_rdata, fill_busy, zs_valid, eb_wr, smp_ready}));
    for (int v = 0; v < 16; v++) cfg(4'(v));
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
      d = 12'($urandom);
      pm_write(a, d);
      pm_read(a, d);
    end
    fill(FILL_PULSE, 12'($urandom));
    fill(FILL_RAMP_DN, 12'h000);
    fill(FILL_RAMP_UP, 12'h7);
    foreach (modes[i]) begin
      cfg(modes[i]);
      send(modes[i], (i == 3) ? 4100 : 40);
    end
    drain();
    cfg(4'h0);
    stall <= 1'b1;
    send(4'h0, 2);
    #1 chk("smp_ready", 16'h0, 16'(smp_ready));
    @(posedge mclk);
    stall <= 1'b0;
    drain();
    for (int i = 0; i < 8; i++) begin
      cfg(i[0] ? 4'h2 : 4'h0);
      @(posedge mclk);
      eb_in_wr   <= 1'b1;
      eb_in_addr <= 20'($urandom);
      eb_in_data <= 12'($urandom);
      @(posedge mclk);
      #1 chk("eb_data", {4'h1, i[0] ? eb_in_addr[11:0] : eb_in_data}, {3'h0, eb_wr, eb_data});
      chk("eb_addr", eb_in_addr[15:0], eb_addr[15:0]);
      chk("eb_addr_hi", 16'(eb_in_addr[19:16]), 16'(eb_addr[19:16]));
    end
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 chk("reset2", 16'h1, 16'({cfg_rdata, fill_busy, zs_valid, eb_wr, smp_ready}));
    chk("reset2_addr", 16'h0, eb_addr[15:0]);
    stop_test();
  end
endmodule : tps_top_bench
`default_nettype wire
